// ---- verilog/bbs_pkg.sv ----
/*
  Shared constants of the battery-backed SRAM host port: pin widths,
  pin timing in ns, and the clock counts derived from them.
  Assumes a single 100 MHz clock and the faster (70 ns) speed grade.
*/
package bbs_pkg;
  // Memory organisation
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int DEPTH = 524288;
  // Clock
  localparam int CLK_PERIOD_NS = 10;
  // Read side, worst-case device delays in ns
  localparam int ADDR_ACCESS_DELAY_NS = 70;
  localparam int SELECT_ACCESS_DELAY_NS = 70;
  localparam int DRIVE_ACCESS_DELAY_NS = 35;
  localparam int SELECT_FLOAT_NS = 30;
  localparam int WRITE_FLOAT_DELAY_NS = 25;
  // Write side, least times in ns
  localparam int WRITE_PULSE_NS = 55;
  localparam int ADDR_TO_WRITE_END_NS = 65;
  localparam int DATA_SETUP_TO_WRITE_END_NS = 30;
  localparam int SELECT_ADDR_HOLD_NS = 15;
  localparam int WRITE_ADDR_HOLD_NS = 5;
  localparam int DATA_HOLD_AFTER_SELECT_NS = 10;
  // Recovery after supply return, longest figure in ms
  localparam int SELECT_RECOVERY_DELAY_MS = 120;
  // Least times round up to whole cycles
  localparam int RD_ACCESS_CYC = (ADDR_ACCESS_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_PULSE_CYC = (WRITE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_ADDR_CYC = (ADDR_TO_WRITE_END_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WR_LOW_CYC = (WR_ADDR_CYC > WR_PULSE_CYC) ? WR_ADDR_CYC : WR_PULSE_CYC;
  localparam int ADDR_HOLD_CYC = (SELECT_ADDR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int FLOAT_CYC = (SELECT_FLOAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int HOLD_CYC = (FLOAT_CYC > ADDR_HOLD_CYC) ? FLOAT_CYC : ADDR_HOLD_CYC;
  localparam int RECOVERY_CYC = SELECT_RECOVERY_DELAY_MS * (1000000 / CLK_PERIOD_NS);
  // Timer width, wide enough for the recovery count
  localparam int TMR_W = 24;
endpackage

// ---- verilog/bbs_tmr_if.sv ----
/*
  Carrier between the host sequencer and its down-counter.
  Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface bbs_tmr_if #(parameter int W = 24);
  logic load;
  logic [W-1:0] load_val;
  logic done;
  modport ctl (output load, output load_val, input done);
  modport tmr (input load, input load_val, output done);
endinterface // bbs_tmr_if

// ---- verilog/bbs_tmr.sv ----
/*
  Down-counter that times the access, hold and recovery phases of the host sequencer.
  Assumes load is a one-cycle request from the sequencer.
*/
`timescale 1ns/10ps
module bbs_tmr import bbs_pkg::*; #(
  parameter int W = TMR_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Sequencer side
  bbs_tmr_if.tmr tif
);
  typedef struct packed {
    logic [W-1:0] cnt;
  } bbs_tmr_s;

  bbs_tmr_s st_reg;
  bbs_tmr_s st_next;

  // Load wins over counting; stops at zero
  always_comb begin
    st_next = st_reg;
    if (tif.load) begin
      st_next.cnt = tif.load_val;
    end else if (st_reg.cnt != '0) begin
      st_next.cnt = st_reg.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Done is seen in the last cycle of a phase
  assign tif.done = (st_reg.cnt == '0);
endmodule // bbs_tmr

// ---- verilog/bbs_host.sv ----
/*
  Host-side controller for a battery-backed 512K x 8 asynchronous SRAM.
  Turns single-word user requests into timed pin sequences.
  Every access takes ten cycles: seven with the strobes low, three of hold.
  Select and write fall together on a write, so the device never drives
  the data lines while the host does.
  A read answers with one valid pulse; a write answers with nothing.
  Assumes the pins and the power-fail flag are synchronous to clk and
  the memory is of the 70 ns grade; tri-state resolution is outside.
*/
// Overview of operation
// - Write spans later fall to earlier rise
// - Address stable, valid 65 ns before end
// - Write or select low at least 55 ns
// - Address held 15 ns after select rises
// - Data setup 30 ns, hold 10 ns
// - Output enable kept high during writes
`timescale 1ns/10ps
module bbs_host import bbs_pkg::*; #(
  parameter int AW = ADDR_W,
  parameter int DW = DATA_W,
  parameter int REC_CYC = RECOVERY_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // User request
  input wire logic req,
  input wire logic req_write,
  input wire logic [AW-1:0] req_addr,
  input wire logic [DW-1:0] req_wdata,
  output logic req_ready,
  // User answer
  output logic rsp_valid,
  output logic [DW-1:0] rsp_rdata,
  // Supply monitor
  input wire logic pfail,
  output logic mem_blocked,
  // Memory pins
  output logic [AW-1:0] byte_select_lines,
  output logic ce_n,
  output logic oe_n,
  output logic we_n,
  // Memory data
  input wire logic [DW-1:0] bidir_byte_lines_in,
  output logic [DW-1:0] bidir_byte_lines_out,
  output logic bidir_byte_lines_oe
);
  // Sequencer phases
  typedef enum logic [2:0] {
    BBS_IDLE, // Waiting for a request
    BBS_ACCESS, // Strobes low, timed access
    BBS_HOLD, // Strobes high, address held
    BBS_PF_WAIT, // Supply failing, no access
    BBS_PF_RECOVER // Supply back, waiting out recovery
  } bbs_state_e;

  // Everything the sequencer remembers, pins included
  typedef struct packed {
    bbs_state_e fsm;
    logic is_wr;
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [DW-1:0] rdata;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic dq_oe;
    logic rsp;
    logic blocked;
  } bbs_host_s;

  // A phase of N cycles loads N-1; done shows in its last cycle
  localparam logic [TMR_W-1:0] RD_LOAD = TMR_W'(RD_ACCESS_CYC - 1);
  localparam logic [TMR_W-1:0] WR_LOAD = TMR_W'(WR_LOW_CYC - 1);
  localparam logic [TMR_W-1:0] HOLD_LOAD = TMR_W'(HOLD_CYC - 1);
  localparam logic [TMR_W-1:0] REC_LOAD = TMR_W'(REC_CYC - 1);

  // Idle pin levels; reset and nothing else lands here
  localparam bbs_host_s ST_RESET = '{
    fsm: BBS_IDLE,
    is_wr: 1'b0,
    addr: '0,
    wdata: '0,
    rdata: '0,
    ce_n: 1'b1,
    oe_n: 1'b1,
    we_n: 1'b1,
    dq_oe: 1'b0,
    rsp: 1'b0,
    blocked: 1'b0
  };

  // Whole state in one word; next value built below
  bbs_host_s st_reg;
  bbs_host_s st_next;
  bbs_tmr_if #(.W(TMR_W)) tif ();

  // Shared down-counter times the access, hold and recovery phases
  bbs_tmr #(.W(TMR_W)) u_tmr (
    .clk(clk),
    .rstn(rstn),
    .tif(tif)
  );

  // Sequencer: one access at a time, access, hold and recovery phases timed by the counter
  always_comb begin
    st_next = st_reg;
    st_next.rsp = 1'b0;
    tif.load = 1'b0;
    tif.load_val = '0;
    case (st_reg.fsm)
      BBS_IDLE: begin
        if (pfail) begin
          // Stop starting accesses; the device is about to deselect
          st_next.fsm = BBS_PF_WAIT;
          st_next.blocked = 1'b1;
        end else if (req) begin
          // Latch the whole request; pins move on the next edge
          st_next.is_wr = req_write;
          st_next.addr = req_addr;
          st_next.wdata = req_wdata;
          st_next.ce_n = 1'b0;
          st_next.we_n = !req_write;
          // Write: select and write fall together, on the same edge as the address changes
          st_next.oe_n = req_write;
          st_next.dq_oe = req_write;
          tif.load = 1'b1;
          tif.load_val = req_write ? WR_LOAD : RD_LOAD;
          st_next.fsm = BBS_ACCESS;
        end
      end
      BBS_ACCESS: begin
        // A started access always completes, power fail or not
        if (tif.done) begin
          // Writes give no answer; ready returning is their end
          if (!st_reg.is_wr) begin
            // Sampled after the full address access delay
            st_next.rdata = bidir_byte_lines_in;
            st_next.rsp = 1'b1;
          end
          // Both strobes rise together, ending the write
          st_next.ce_n = 1'b1;
          st_next.we_n = 1'b1;
          st_next.oe_n = 1'b1;
          tif.load = 1'b1;
          tif.load_val = HOLD_LOAD;
          st_next.fsm = BBS_HOLD;
        end
      end
      BBS_HOLD: begin
        // Data kept one cycle past the strobe edge, address kept longer
        st_next.dq_oe = 1'b0;
        if (tif.done) begin
          st_next.fsm = BBS_IDLE;
          if (!st_reg.is_wr) begin
            st_next.rsp = 1'b0;
          end
        end
      end
      BBS_PF_WAIT: begin
        // No access until the supply comes back
        if (!pfail) begin
          tif.load = 1'b1;
          tif.load_val = REC_LOAD;
          st_next.fsm = BBS_PF_RECOVER;
        end
      end
      BBS_PF_RECOVER: begin
        // Wait out the longest recovery so the first access is never lost
        if (pfail) begin
          // Supply dipped again: start the wait over
          st_next.fsm = BBS_PF_WAIT;
        end else if (tif.done) begin
          st_next.blocked = 1'b0;
          st_next.fsm = BBS_IDLE;
        end
      end
      default: begin
        // Unused codes fall back to idle
        st_next.fsm = BBS_IDLE;
      end
    endcase
  end

  // Async reset drops straight to the idle pin levels
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // Ready is combinational; answer, pins and data come from flops
  assign req_ready = (st_reg.fsm == BBS_IDLE) && !pfail;
  assign rsp_valid = st_reg.rsp;
  assign rsp_rdata = st_reg.rdata;
  assign mem_blocked = st_reg.blocked;

  // Memory pins straight from the state word, so they never glitch
  assign byte_select_lines = st_reg.addr;
  assign ce_n = st_reg.ce_n;
  assign oe_n = st_reg.oe_n;
  assign we_n = st_reg.we_n;
  assign bidir_byte_lines_out = st_reg.wdata;
  assign bidir_byte_lines_oe = st_reg.dq_oe;
endmodule // bbs_host

// ---- testbench/bbs_sram_model.sv ----
/*
  Behavioural model of the 512K x 8 battery-backed SRAM.
  Assumes the bench resolves the shared data pins.
*/
`timescale 1ns/10ps
module bbs_sram_model #(
  parameter real DLY = 65.0
) (
  // Control and address pins
  input logic ce_n,
  input logic oe_n,
  input logic we_n,
  input logic [18:0] addr,
  // Data pins
  input logic [7:0] din,
  output logic [7:0] dq
);
  logic [7:0] mem [0:524287];
  logic [7:0] last = 8'h00;
  logic wr = 1'b0;
  wire drv = !ce_n && !oe_n && we_n;
  // Slow answer; released lines show the inverse, not a stale byte
  assign #(DLY) dq = drv ? mem[addr] : ~last;
  always @(negedge drv) last = dq;
  // Write ends at the earlier rise of select or write strobe
  always @(ce_n or we_n) begin
    if (wr && (ce_n || we_n)) mem[addr] = din;
    wr = !ce_n && !we_n;
  end
endmodule // bbs_sram_model

// ---- testbench/bbs_host_chk.sv ----
/*
  Pin-level checker for the host port.
  Assumes it is bound to bbs_host and sees only its ports.
*/
`timescale 1ns/10ps
module bbs_host_chk #(parameter int AW = 19, parameter int DW = 8) (
  // Clock and reset
  input logic clk,
  input logic rstn,
  // User side
  input logic req,
  input logic req_write,
  input logic req_ready,
  input logic rsp_valid,
  input logic [DW-1:0] rsp_rdata,
  input logic mem_blocked,
  // Memory pins
  input logic [AW-1:0] byte_select_lines,
  input logic ce_n,
  input logic oe_n,
  input logic we_n,
  input logic [DW-1:0] bidir_byte_lines_in,
  input logic [DW-1:0] bidir_byte_lines_out,
  input logic bidir_byte_lines_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_WR_OE_HIGH: assert property (!we_n |-> oe_n && !ce_n)
    else $error("output enable low in write");
  AST_WR_PULSE: assert property ($fell(we_n) |-> !we_n[*7])
    else $error("write pulse short");
  AST_ADDR_STABLE: assert property (!ce_n && !$fell(ce_n) |-> $stable(byte_select_lines))
    else $error("address moved in access");
  AST_ADDR_HOLD: assert property ($rose(ce_n) |-> $stable(byte_select_lines)[*3])
    else $error("address hold short");
  AST_DATA_HOLD: assert property ($rose(we_n) |-> bidir_byte_lines_oe)
    else $error("data released at write end");
  AST_END_TOGETHER: assert property ($rose(we_n) |-> $rose(ce_n))
    else $error("write end split");
  AST_RD_ANSWER: assert property (req && req_ready && !req_write |-> ##8 rsp_valid)
    else $error("read answer late");
  AST_RD_DATA: assert property (rsp_valid |-> rsp_rdata == $past(bidir_byte_lines_in))
    else $error("read data wrong");
  AST_NO_ACC_BLK: assert property ($fell(ce_n) |-> !mem_blocked)
    else $error("access while blocked");
  C_WR: cover property ($rose(we_n));
  C_RD: cover property (rsp_valid);
  C_BLK: cover property ($fell(mem_blocked));
endmodule // bbs_host_chk
bind bbs_host bbs_host_chk #(.AW(AW), .DW(DW)) u_chk (.*);

// ---- testbench/test_battery_backed_async_sram_port.sv ----
/*
  Self-checking bench for the SRAM host port against a device model.
  Assumes REC_CYC is shortened to 20 cycles.
*/
`timescale 1ns/10ps
module test_battery_backed_async_sram_port;
  import bbs_pkg::*;
  logic clk = 0, rstn = 0, req = 0, req_write = 0, pfail = 0;
  logic [18:0] req_addr = 0;
  logic [7:0] req_wdata = 0;
  logic req_ready, rsp_valid, mem_blocked, ce_n, oe_n, we_n, doe;
  logic [7:0] rsp_rdata, dout, dq, din;
  logic [18:0] a;
  int mismatches = 0, cmp_count = 0, cyc = 0;
  localparam int REC = 20;
  // Host wins the shared lines only while it drives them
  assign din = doe ? dout : dq;
  bbs_host #(.REC_CYC(REC)) u_bbs_host (.clk(clk), .rstn(rstn), .req(req),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
    .pfail(pfail), .mem_blocked(mem_blocked), .byte_select_lines(a),
    .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .bidir_byte_lines_in(din),
    .bidir_byte_lines_out(dout), .bidir_byte_lines_oe(doe));
  bbs_sram_model u_bbs_sram_model (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
    .addr(a), .din(dout), .dq(dq));
  initial begin
    forever #5 clk = ~clk;
  end
  task chk(string n, logic [31:0] s, logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, s);
    end
  endtask
  task end_sim();
    $display("checks %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Waits for ready, then offers one request for one edge
  task go(logic w, logic [18:0] ad, logic [7:0] d);
    @(negedge clk);
    while (req_ready !== 1'b1) @(negedge clk);
    @(posedge clk);
    req <= 1;
    req_write <= w;
    req_addr <= ad;
    req_wdata <= d;
    @(posedge clk);
    req <= 0;
  endtask
  task rd(logic [18:0] ad, logic [7:0] e);
    go(0, ad, 8'h00);
    repeat (7) @(posedge clk);
    @(negedge clk);
    chk("rsp_valid", rsp_valid, 1);
    chk("rsp_rdata", rsp_rdata, e);
  endtask
  task t_rw();
    go(1, 19'h00000, 8'ha5);
    go(1, 19'h7ffff, 8'h3c);
    go(1, 19'h12345, 8'hff);
    rd(19'h7ffff, 8'h3c);
    rd(19'h00000, 8'ha5);
    rd(19'h12345, 8'hff);
    $display("t_rw done");
  endtask
  task t_pf_idle();
    @(posedge clk);
    pfail <= 1;
    req <= 1;
    req_addr <= 19'h00000;
    repeat (3) @(posedge clk);
    @(negedge clk);
    chk("blocked", mem_blocked, 1);
    chk("ce_n", ce_n, 1);
    @(posedge clk);
    req <= 0;
    pfail <= 0;
    // Pfail low is seen one edge later; recovery ends REC edges after that
    repeat (REC) @(posedge clk);
    @(negedge clk);
    chk("rec_ready", req_ready, 0);
    chk("rec_blocked", mem_blocked, 1);
    @(posedge clk);
    @(negedge clk);
    chk("unblocked", mem_blocked, 0);
    chk("rec_done_ready", req_ready, 1);
    rd(19'h00000, 8'ha5);
    $display("t_pf_idle done");
  endtask
  task t_pf_mid();
    go(1, 19'h00abc, 8'h55);
    pfail <= 1;
    repeat (12) @(posedge clk);
    chk("mid_blocked", mem_blocked, 1);
    pfail <= 0;
    rd(19'h00abc, 8'h55);
    $display("t_pf_mid done");
  endtask
  // Hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      mismatches++;
      end_sim();
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1;
    t_rw();
    t_pf_idle();
    t_pf_mid();
    end_sim();
  end
endmodule // test_battery_backed_async_sram_port
